// *** bench/tbid_decoder_asserts.sv ***
`timescale 1ns/1ps
// ****
// Decoder timing and field checks
// ****
module tbid_decoder_asserts (
    input wire logic mclk,
    input wire logic reset,
    input wire logic fetch,
    input wire logic issue,
    input wire logic [1:0] cat,
    input wire logic dest_file,
    input wire logic [6:0] file_addr,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] bit_mask,
    input wire logic [8:0] literal,
    input wire logic lit_is_9bit,
    input wire logic pc_change,
    input wire logic two_cycle,
    input wire logic flush
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sequence long_s; issue ##2 two_cycle; endsequence
    sequence short_s; issue ##2 !two_cycle; endsequence
    sequence dummy_s; !fetch ##1 (!fetch && flush) [*3] ##1 (fetch && flush); endsequence
    a_fetch_spacing: assert property (fetch |=> !fetch [*3])
        else $error("fetch too close");
    a_issue_follows: assert property (fetch |=> issue)
        else $error("no issue after fetch");
    a_fields_hold: assert property (!fetch |=> $stable({cat, literal, file_addr}))
        else $error("fields moved between fetches");
    a_lit_width: assert property (lit_is_9bit ? cat == 2'h3 : !literal[8])
        else $error("literal width wrong");
    a_mask_onehot: assert property (bit_mask == (cat == 2'h1 ? 8'h01 << bit_sel : 8'h00))
        else $error("bit mask wrong");
    a_dest_byte: assert property (cat != 2'h0 |-> !dest_file)
        else $error("destination outside byte op");
    a_file_range: assert property (!file_addr[6:5] && (cat != 2'h3 || !file_addr))
        else $error("file address out of field");
    a_cat_legal: assert property (cat != 2'h2)
        else $error("illegal category");
    a_pc_two: assert property (issue && pc_change |-> ##2 two_cycle)
        else $error("jump took one cycle");
    a_long_instr: assert property (long_s |=> dummy_s)
        else $error("two cycle timing wrong");
    a_short_instr: assert property (short_s |=> fetch && !flush)
        else $error("one cycle timing wrong");
endmodule

// *** bench/tbid_decoder_bench.sv ***
`timescale 1ns/1ps
module tbid_decoder_bench
    import tbid_pkg::*;
;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic cond_true = 1'b0;
    logic [11:0] next_word = 12'h000;
    logic [11:0] instr_word;
    logic fetch, issue, dest_file, lit_is_9bit, pc_change, two_cycle, flush;
    logic [1:0] cat;
    logic [4:0] op;
    logic [6:0] file_addr;
    logic [2:0] bit_sel;
    logic [7:0] bit_mask;
    logic [8:0] literal;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;
    tbid_progmem mem_u (.fetch(fetch), .next_word(next_word), .instr_word(instr_word));
    tbid_decoder dut_u (.mclk(mclk), .reset(reset), .instr_word(instr_word),
        .cond_true(cond_true), .fetch(fetch), .issue(issue), .cat(cat), .op(op),
        .dest_file(dest_file), .file_addr(file_addr), .bit_sel(bit_sel), .bit_mask(bit_mask),
        .literal(literal), .lit_is_9bit(lit_is_9bit), .pc_change(pc_change),
        .two_cycle(two_cycle), .flush(flush));
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic exec(input logic [11:0] w, input logic c, input tbid_op_t e);
        logic [1:0] ce;
        logic j9, pcc, two;
        int n;
        ce = (w[11:10] == 2'h0) ? 2'h0 : (w[11:10] == 2'h1) ? 2'h1 : 2'h3;
        j9 = (w[11:9] == 3'h5);
        pcc = j9 || (w[11:9] == 3'h4) || (w[11:10] == 2'h0 && w[5:0] == 6'h22);
        two = pcc || (c && (w[11:9] == 3'h3 || w[11:6] == 6'h0B || w[11:6] == 6'h0F));
        next_word = w;
        n = 0;
        while (fetch !== 1'b1 && n < 9) begin
            @(negedge mclk);
            n++;
        end
        @(negedge mclk);
        cond_true = c;
        check({11'h0, issue}, 12'h001);
        check({10'h0, cat}, {10'h0, ce});
        check({7'h0, op}, {7'h0, e});
        check({11'h0, dest_file}, {11'h0, ce == 2'h0 && w[5]});
        check({5'h0, file_addr}, (ce == 2'h3) ? 12'h000 : {7'h0, w[4:0]});
        check({1'h0, bit_sel, bit_mask},
            (ce == 2'h1) ? {1'h0, w[7:5], 8'h01 << w[7:5]} : 12'h000);
        check({pc_change, lit_is_9bit, 1'h0, literal},
            {pcc, j9, 1'h0, j9 ? w[8:0] : (ce == 2'h3) ? {1'h0, w[7:0]} : 9'h000});
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (fetch !== 1'b1 && n < 9);
        check(12'(n), two ? 12'h007 : 12'h003);
        check({10'h0, two_cycle, flush}, {10'h0, two, two});
    endtask
    task automatic t_byte();
        exec(12'h1DF, 1'b0, TBID_OP_ADDWF);
        exec(12'h200, 1'b0, TBID_OP_MOVF);
        exec(12'h2C5, 1'b1, TBID_OP_DECFSZ);
        exec(12'h2C5, 1'b0, TBID_OP_DECFSZ);
    endtask
    task automatic t_bit();
        exec(12'h5E3, 1'b0, TBID_OP_BSF);
        exec(12'h71F, 1'b1, TBID_OP_BTFSS);
        exec(12'h41F, 1'b1, TBID_OP_BCF);
    endtask
    task automatic t_lit();
        exec(12'hCFF, 1'b0, TBID_OP_MOVLW);
        exec(12'hF5A, 1'b0, TBID_OP_XORLW);
        exec(12'h880, 1'b0, TBID_OP_RETLW);
        exec(12'h912, 1'b0, TBID_OP_CALL);
    endtask
    task automatic t_jump();
        exec(12'hBFF, 1'b0, TBID_OP_GOTO);
        exec(12'hA00, 1'b1, TBID_OP_GOTO);
        exec(12'h022, 1'b0, TBID_OP_MOVWF);
    endtask
    task automatic t_more();
        exec(12'h000, 1'b1, TBID_OP_MISC);
        exec(12'h060, 1'b0, TBID_OP_CLR);
        exec(12'h0A1, 1'b0, TBID_OP_SUBWF);
        exec(12'h0C3, 1'b0, TBID_OP_DECF);
        exec(12'h104, 1'b0, TBID_OP_IORWF);
        exec(12'h145, 1'b0, TBID_OP_ANDWF);
        exec(12'h1A6, 1'b0, TBID_OP_XORWF);
        exec(12'h247, 1'b0, TBID_OP_COMF);
        exec(12'h288, 1'b0, TBID_OP_INCF);
        exec(12'h309, 1'b0, TBID_OP_RRF);
        exec(12'h36A, 1'b0, TBID_OP_RLF);
        exec(12'h3AB, 1'b0, TBID_OP_SWAPF);
        exec(12'h3CC, 1'b1, TBID_OP_INCFSZ);
        exec(12'h6A7, 1'b1, TBID_OP_BTFSC);
        exec(12'h6A7, 1'b0, TBID_OP_BTFSC);
        exec(12'hD3C, 1'b0, TBID_OP_IORLW);
        exec(12'hE0F, 1'b0, TBID_OP_ANDLW);
        exec(12'h1E2, 1'b0, TBID_OP_ADDWF);
    endtask
    task automatic t_reset();
        @(negedge mclk);
        reset = 1'b1;
        @(negedge mclk);
        check({cat, op, lit_is_9bit, pc_change, two_cycle, flush, issue}, 12'h001);
        check({file_addr, bit_sel, dest_file, 1'b0}, 12'h000);
        check({bit_mask, 4'h0}, 12'h000);
        check({literal, 3'h0}, 12'h000);
        reset = 1'b0;
    endtask
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        repeat (8) @(negedge mclk);
        reset = 1'b0;
        t_byte();
        t_bit();
        t_lit();
        t_jump();
        t_more();
        t_reset();
        t_lit();
        give_verdict();
    end
endmodule
bind tbid_decoder tbid_decoder_asserts chk_u (.mclk(mclk), .reset(reset), .fetch(fetch),
    .issue(issue), .cat(cat), .dest_file(dest_file), .file_addr(file_addr),
    .bit_sel(bit_sel), .bit_mask(bit_mask), .literal(literal), .lit_is_9bit(lit_is_9bit),
    .pc_change(pc_change), .two_cycle(two_cycle), .flush(flush));

// *** bench/tbid_progmem.sv ***
`timescale 1ns/1ps
module tbid_progmem (
    input wire logic fetch,
    input wire logic [11:0] next_word,
    output logic [11:0] instr_word
);
    // Off the fetch cycle the bus shows the inverse, so a mistimed latch cannot pass by luck.
    assign instr_word = fetch ? next_word : ~next_word;
endmodule

// *** hdl/tbid_decoder.sv ***
`timescale 1ns/1ps
`include "tbid_regs.svh"
module tbid_decoder
    import tbid_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [11:0] instr_word,
    input wire logic cond_true,
    output logic fetch,
    output logic issue,
    output logic [1:0] cat,
    output logic [4:0] op,
    output logic dest_file,
    output logic [6:0] file_addr,
    output logic [2:0] bit_sel,
    output logic [7:0] bit_mask,
    output logic [8:0] literal,
    output logic lit_is_9bit,
    output logic pc_change,
    output logic two_cycle,
    output logic flush
);
    // ***************************************************************
    // State
    // ***************************************************************
    typedef struct packed {
        tbid_q_t q;
        logic second;
        tbid_cat_t cat;
        tbid_op_t op;
        logic dest;
        logic [6:0] faddr;
        logic [2:0] bsel;
        logic [7:0] mask;
        logic [8:0] lit;
        logic lit9;
        logic pcc;
        logic two;
    } tbid_st_t;

    tbid_st_t st_r;
    tbid_st_t st_nxt;
    tbid_cat_t dec_cat;
    tbid_op_t dec_op;

    // ***************************************************************
    // Decode helpers
    // ***************************************************************
    function automatic logic [7:0] bit_onehot(input logic [2:0] b);
        bit_onehot = 8'h01 << b;
    endfunction

    // Byte and bit formats share the low file field; banking lives outside this block.
    function automatic logic [6:0] file_field(input logic [11:0] w);
        file_field = {2'h0, w[`TBID_FILE_MSB:0]};
    endfunction

    // Any byte op that stores to file 2 rewrites the low program counter byte.
    function automatic logic is_pc_write(input tbid_cat_t c, input logic [11:0] w);
        is_pc_write = (c == TBID_CAT_BYTE) && w[`TBID_DEST_BIT] &&
                      (w[`TBID_FILE_MSB:0] == `TBID_PCL_ADDR);
    endfunction

    function automatic logic is_skip(input tbid_op_t o);
        is_skip = (o == TBID_OP_DECFSZ) || (o == TBID_OP_INCFSZ) ||
                  (o == TBID_OP_BTFSC) || (o == TBID_OP_BTFSS);
    endfunction

    tbid_opdec u_opdec (
        .iw(instr_word),
        .cat(dec_cat),
        .op(dec_op)
    );

    // ***************************************************************
    // Quarter sequencer and field capture
    // ***************************************************************
    // The word is latched at the end of Q4 so fields hold for a whole cycle.
    always_comb begin
        st_nxt = st_r;
        unique case (st_r.q)
            TBID_Q1: st_nxt.q = TBID_Q2;
            TBID_Q2: st_nxt.q = TBID_Q3;
            TBID_Q3: st_nxt.q = TBID_Q4;
            TBID_Q4: st_nxt.q = TBID_Q1;
        endcase
        if (st_r.q == TBID_Q4) begin
            if (st_r.two && !st_r.second) begin
                // The fetch waits one whole dummy cycle, so the bus word is not taken here.
                st_nxt.second = 1'b1;
            end else begin
                st_nxt.second = 1'b0;
                st_nxt.cat = dec_cat;
                st_nxt.op = dec_op;
                // Field extraction ignores bits outside each format.
                st_nxt.dest = 1'b0;
                st_nxt.faddr = `TBID_FILE_MIN;
                st_nxt.bsel = 3'h0;
                st_nxt.mask = 8'h00;
                st_nxt.lit = 9'h000;
                st_nxt.lit9 = 1'b0;
                unique case (dec_cat)
                    TBID_CAT_BYTE: begin
                        st_nxt.dest = instr_word[`TBID_DEST_BIT];
                        st_nxt.faddr = file_field(instr_word);
                    end
                    TBID_CAT_BIT: begin
                        st_nxt.bsel = instr_word[`TBID_BIT_MSB:`TBID_BIT_LSB];
                        st_nxt.mask = bit_onehot(st_nxt.bsel);
                        st_nxt.faddr = file_field(instr_word);
                    end
                    TBID_CAT_LIT: begin
                        if (dec_op == TBID_OP_GOTO) begin
                            st_nxt.lit = instr_word[`TBID_LIT9_MSB:0];
                            st_nxt.lit9 = 1'b1;
                        end else begin
                            st_nxt.lit = {1'b0, instr_word[`TBID_LIT8_MSB:0]};
                        end
                    end
                    default: st_nxt.cat = TBID_CAT_LIT;
                endcase
                st_nxt.pcc = (dec_op == TBID_OP_GOTO) || (dec_op == TBID_OP_CALL) ||
                             (dec_op == TBID_OP_RETLW) || is_pc_write(dec_cat, instr_word);
                st_nxt.two = 1'b0;
            end
        end
        // Taken skip or program counter change is known during Q2.
        if (st_r.q == TBID_Q2 && !st_r.second) begin
            st_nxt.two = st_r.pcc || (is_skip(st_r.op) && cond_true);
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_r <= '{
                q: TBID_Q1,
                second: 1'b0,
                cat: TBID_CAT_BYTE,
                op: TBID_OP_NOP,
                dest: 1'b0,
                faddr: 7'h00,
                bsel: 3'h0,
                mask: 8'h00,
                lit: 9'h000,
                lit9: 1'b0,
                pcc: 1'b0,
                two: 1'b0
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    // ***************************************************************
    // Outputs
    // ***************************************************************
    assign fetch = (st_r.q == TBID_Q4) && (st_r.second || !st_r.two);
    assign issue = (st_r.q == TBID_Q1) && !st_r.second;
    assign cat = st_r.cat;
    assign op = st_r.op;
    assign dest_file = st_r.dest;
    assign file_addr = st_r.faddr;
    assign bit_sel = st_r.bsel;
    assign bit_mask = st_r.mask;
    assign literal = st_r.lit;
    assign lit_is_9bit = st_r.lit9;
    assign pc_change = st_r.pcc;
    assign two_cycle = st_r.two;
    assign flush = st_r.second;
endmodule

// *** hdl/tbid_opdec.sv ***
`timescale 1ns/1ps
`include "tbid_regs.svh"
module tbid_opdec
    import tbid_pkg::*;
(
    input wire logic [11:0] iw,
    output tbid_cat_t cat,
    output tbid_op_t op
);
    // Opcode bits are examined here, plus destination bit 5, which splits MOVWF from MISC.
    always_comb begin
        cat = TBID_CAT_LIT;
        op = TBID_OP_NOP;
        if (iw[11:10] == 2'h0) begin
            cat = TBID_CAT_BYTE;
            unique case (iw[9:6])
                4'h0: op = iw[5] ? TBID_OP_MOVWF : TBID_OP_MISC;
                4'h1: op = TBID_OP_CLR;
                4'h2: op = TBID_OP_SUBWF;
                4'h3: op = TBID_OP_DECF;
                4'h4: op = TBID_OP_IORWF;
                4'h5: op = TBID_OP_ANDWF;
                4'h6: op = TBID_OP_XORWF;
                4'h7: op = TBID_OP_ADDWF;
                4'h8: op = TBID_OP_MOVF;
                4'h9: op = TBID_OP_COMF;
                4'hA: op = TBID_OP_INCF;
                4'hB: op = TBID_OP_DECFSZ;
                4'hC: op = TBID_OP_RRF;
                4'hD: op = TBID_OP_RLF;
                4'hE: op = TBID_OP_SWAPF;
                4'hF: op = TBID_OP_INCFSZ;
            endcase
        end else if (iw[11:10] == 2'h1) begin
            cat = TBID_CAT_BIT;
            unique case (iw[9:8])
                2'h0: op = TBID_OP_BCF;
                2'h1: op = TBID_OP_BSF;
                2'h2: op = TBID_OP_BTFSC;
                2'h3: op = TBID_OP_BTFSS;
            endcase
        end else begin
            unique case (iw[11:8])
                4'h8: op = TBID_OP_RETLW;
                4'h9: op = TBID_OP_CALL;
                4'hA, 4'hB: op = TBID_OP_GOTO;
                4'hC: op = TBID_OP_MOVLW;
                4'hD: op = TBID_OP_IORLW;
                4'hE: op = TBID_OP_ANDLW;
                default: op = TBID_OP_XORLW;
            endcase
        end
    end
endmodule

// *** hdl/tbid_pkg.sv ***
package tbid_pkg;
    typedef enum logic [1:0] {
        TBID_CAT_BYTE = 2'h0,
        TBID_CAT_BIT = 2'h1,
        TBID_CAT_LIT = 2'h3
    } tbid_cat_t;
    typedef enum logic [1:0] {
        TBID_Q1 = 2'h0,
        TBID_Q2 = 2'h1,
        TBID_Q3 = 2'h3,
        TBID_Q4 = 2'h2
    } tbid_q_t;
    typedef enum logic [4:0] {
        TBID_OP_NOP, TBID_OP_MISC, TBID_OP_MOVWF, TBID_OP_CLR, TBID_OP_SUBWF,
        TBID_OP_DECF, TBID_OP_IORWF, TBID_OP_ANDWF, TBID_OP_XORWF, TBID_OP_ADDWF,
        TBID_OP_MOVF, TBID_OP_COMF, TBID_OP_INCF, TBID_OP_DECFSZ, TBID_OP_RRF,
        TBID_OP_RLF, TBID_OP_SWAPF, TBID_OP_INCFSZ, TBID_OP_BCF, TBID_OP_BSF,
        TBID_OP_BTFSC, TBID_OP_BTFSS, TBID_OP_RETLW, TBID_OP_CALL, TBID_OP_GOTO,
        TBID_OP_MOVLW, TBID_OP_IORLW, TBID_OP_ANDLW, TBID_OP_XORLW
    } tbid_op_t;
endpackage

// *** hdl/tbid_regs.svh ***
// Summary of operation
// - Instruction words are twelve bits wide.
// - Each word falls in exactly one category.
// - Destination bit zero selects working register.
// - File address spans files 0 to 31 of the register file range.
// - Bit field picks one of eight bits.
// - Literal operand is eight or nine bits.
// - Taken test or jump costs two cycles.
// - Instruction cycle equals four oscillator periods.
// - Byte format: opcode, destination, file address.
// - Bit format: bit select and file address.
// - Literal format: opcode high, eight-bit literal.
// - Jump format: three-bit opcode, nine-bit target.
`ifndef TBID_REGS_SVH
`define TBID_REGS_SVH
`define TBID_IW_MSB 11
`define TBID_DEST_BIT 5
`define TBID_FILE_MSB 4
`define TBID_BIT_MSB 7
`define TBID_BIT_LSB 5
`define TBID_LIT8_MSB 7
`define TBID_LIT9_MSB 8
`define TBID_Q_PER_CYCLE 4
`define TBID_FILE_MIN 7'h00
`define TBID_FILE_MAX 7'h7F
`define TBID_PCL_ADDR 5'h02
`endif
